// [pkg/pcs_pkg.sv]
// Constants, types and behaviour notes for the clock source configuration block
// Notes on behaviour
// - PLL power field 00b runs the PLL normally and 01b puts it into asynchronous power-down.
// - The source-select bit picks the internal VCO when 1b and the external clock input when 0b.
// - The bypass bit feeds distribution through the VCO divider when 0b and bypasses it when 1b.
// - The three-bit divider field selects a divide ratio from one to six.
// - Calibration starts when an update strobe commits the calibrate bit as 1b while the active bit is 0b.
// - The three-bit reference enable field enables each reference input on its own.
// - The polarity bit gives positive PFD polarity when 0b and negative polarity when 1b.
// - After reset the PLL is off and the external clock passes through the VCO divider.
// - With the PLL on and the external clock chosen, the VCO is off and the prescaler is fed externally.
// - The configuration can be saved to nonvolatile storage and reloaded at power-up unaided.
package pcs_pkg;

  // Register offsets on the serial port
  localparam logic [12:0] ADDR_PLL_CTRL = 13'h0010;
  localparam logic [12:0] ADDR_VCO_CAL  = 13'h0018;
  localparam logic [12:0] ADDR_REF_EN   = 13'h001c;
  localparam logic [12:0] ADDR_VCO_DIV  = 13'h01e0;
  localparam logic [12:0] ADDR_SRC_SEL  = 13'h01e1;
  localparam logic [12:0] ADDR_UPDATE   = 13'h0232;
  localparam logic [12:0] ADDR_NV_CTRL  = 13'h0b00;

  // Field positions and codes
  localparam int          PFD_POL_BIT    = 7;
  localparam int          CAL_BIT        = 0;
  localparam int          SRC_VCO_BIT    = 1;
  localparam int          DIV_BYP_BIT    = 0;
  localparam int          UPD_BIT        = 0;
  localparam int          NV_SAVE_BIT    = 0;
  localparam int          NV_LOAD_BIT    = 1;
  localparam logic [1:0]  PWR_NORMAL     = 2'h0;
  localparam logic [1:0]  PWR_ASYNC_DOWN = 2'h1;

  // Serial frame: 16 instruction bits then one data byte
  localparam logic [4:0]  CNT_INSTR_LAST = 5'h0f;
  localparam logic [4:0]  CNT_FRAME_LAST = 5'h17;

  typedef struct packed {
    logic [7:0] pll;
    logic [7:0] cal;
    logic [7:0] refen;
    logic [7:0] div;
    logic [7:0] src;
  } pcs_cfg_t;

  // Reset values of the configuration registers
  localparam pcs_cfg_t CFG_RESET = '{pll: 8'h01, cal: 8'h00, refen: 8'h00, div: 8'h00,
                                     src: 8'h00};

  typedef struct packed {
    logic       pll_pwr_down;
    logic       vco_power_on;
    logic       prescaler_ext;
    logic       src_vco;
    logic       div_bypass;
    logic [2:0] div_ratio;
    logic       pfd_negative;
    logic [2:0] ref_en;
    logic       cal_start;
  } pcs_ctrl_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_INSTR = 2'b01,
    ST_DATA  = 2'b10,
    ST_DONE  = 2'b11
  } pcs_spi_st_t;

  typedef struct packed {
    pcs_cfg_t    stg;
    pcs_cfg_t    act;
    pcs_cfg_t    nv;
    pcs_ctrl_t   ctrl;
    pcs_spi_st_t st;
    logic [4:0]  cnt;
    logic [15:0] instr;
    logic [7:0]  dsh;
    logic [7:0]  osh;
    logic        sdo;
    logic        sdo_oe_n;
    logic        sclk_q;
    logic        boot;
  } pcs_state_t;

endpackage

// [logic/pcs_clock_source_config.sv]
// Serial-port configuration logic for PLL power, clock source routing and VCO calibration
`timescale 1ns/100ps
module pcs_clock_source_config
  import pcs_pkg::*;
(
  // Clock and reset
  input  wire logic      CLK,
  input  wire logic      RST,
  // Serial control port
  input  wire logic      SCLK,
  input  wire logic      CS_N,
  input  wire logic      SDI,
  output logic           SDO,
  output logic           SDO_OE_N,
  // Nonvolatile image present at power-up
  input  wire logic      NV_VALID,
  // Clock path control
  output pcs_ctrl_t      CLK_CTRL
);

  pcs_state_t  q;
  pcs_state_t  d;
  logic        rise;
  logic        fall;
  logic [15:0] ins_n;
  logic        wr_en;
  logic [12:0] wr_addr;
  logic [7:0]  wbyte;
  logic        upd_wr;
  logic        stage_wr;
  logic        nv_save_wr;

  // Divider code 000b is divide-by-2; codes above the table fall back to divide-by-1
  function automatic logic [2:0] div_ratio(input logic [2:0] code);
    case (code)
      3'h0:    div_ratio = 3'h2;
      3'h1:    div_ratio = 3'h3;
      3'h2:    div_ratio = 3'h4;
      3'h3:    div_ratio = 3'h5;
      3'h4:    div_ratio = 3'h6;
      default: div_ratio = 3'h1;
    endcase
  endfunction

  function automatic pcs_ctrl_t ctrl_from(input pcs_cfg_t a, input logic cal);
    pcs_ctrl_t c;
    c = '0;
    c.pll_pwr_down  = (a.pll[1:0] == PWR_ASYNC_DOWN);
    c.src_vco       = a.src[SRC_VCO_BIT];
    c.div_bypass    = a.src[DIV_BYP_BIT];
    c.div_ratio     = div_ratio(a.div[2:0]);
    c.pfd_negative  = a.pll[PFD_POL_BIT];
    c.ref_en        = a.refen[2:0];
    // with source-select 0b in normal power, the external oscillator drives the prescaler and the VCO is left unpowered
    c.vco_power_on  = (a.pll[1:0] == PWR_NORMAL) && a.src[SRC_VCO_BIT];
    c.prescaler_ext = (a.pll[1:0] == PWR_NORMAL) && !a.src[SRC_VCO_BIT];
    c.cal_start     = cal;
    return c;
  endfunction

  // Reads return the staged copy so software sees what it wrote before the update
  function automatic logic [7:0] rd_byte(input pcs_cfg_t s, input logic [12:0] addr);
    case (addr)
      ADDR_PLL_CTRL: rd_byte = s.pll;
      ADDR_VCO_CAL:  rd_byte = s.cal;
      ADDR_REF_EN:   rd_byte = s.refen;
      ADDR_VCO_DIV:  rd_byte = s.div;
      ADDR_SRC_SEL:  rd_byte = s.src;
      default:       rd_byte = 8'h00;
    endcase
  endfunction

  // SCLK is sampled as plain data; it must be slow against CLK
  assign rise       = SCLK & ~q.sclk_q;
  assign fall       = ~SCLK & q.sclk_q;
  assign ins_n      = {q.instr[14:0], SDI};
  assign wr_en      = ~CS_N & (q.st == ST_DATA) & rise & (q.cnt == CNT_FRAME_LAST)
                      & ~q.instr[15];
  assign wr_addr    = q.instr[12:0];
  assign wbyte      = {q.dsh[6:0], SDI};
  assign upd_wr     = wr_en && (wr_addr == ADDR_UPDATE) && wbyte[UPD_BIT];
  assign nv_save_wr = wr_en && (wr_addr == ADDR_NV_CTRL) && wbyte[NV_SAVE_BIT];
  assign stage_wr   = wr_en && (wr_addr != ADDR_UPDATE) && !q.boot;

  always_comb begin
    d = q;
    d.sclk_q = SCLK;
    if (CS_N) begin
      d.st  = ST_IDLE;
      d.cnt = 5'h00;
      d.sdo = 1'b0;
    end else begin
      case (q.st)
        ST_IDLE, ST_INSTR: begin
          if (rise) begin
            d.instr = ins_n;
            d.cnt   = q.cnt + 5'h01;
            d.st    = ST_INSTR;
            if (q.cnt == CNT_INSTR_LAST) begin
              d.st  = ST_DATA;
              d.osh = ins_n[15] ? rd_byte(q.stg, ins_n[12:0]) : 8'h00;
            end
          end
        end
        ST_DATA: begin
          if (rise) begin
            d.dsh = wbyte;
            d.cnt = q.cnt + 5'h01;
            if (q.cnt == CNT_FRAME_LAST) begin
              d.st = ST_DONE;
            end
          end
          if (fall && q.instr[15]) begin
            d.sdo = q.osh[7];
            d.osh = {q.osh[6:0], 1'b0};
          end
        end
        ST_DONE: begin
          d.st = ST_DONE;
        end
        default: begin
          d.st = ST_IDLE;
        end
      endcase
    end

    d.ctrl.cal_start = 1'b0;
    if (wr_en) begin
      case (wr_addr)
        // staged writes do not reach the control outputs
        ADDR_PLL_CTRL: d.stg.pll   = wbyte;
        ADDR_VCO_CAL:  d.stg.cal   = wbyte;
        ADDR_REF_EN:   d.stg.refen = wbyte;
        ADDR_VCO_DIV:  d.stg.div   = wbyte;
        ADDR_SRC_SEL:  d.stg.src   = wbyte;
        ADDR_NV_CTRL: begin
          // save active settings, or pull the stored image into staging
          if (wbyte[NV_SAVE_BIT]) begin
            d.nv = q.act;
          end
          if (wbyte[NV_LOAD_BIT]) begin
            d.stg = q.nv;
          end
        end
        default: begin
          d.stg = q.stg;
        end
      endcase
    end

    // update strobe transfers staging to active
    if (upd_wr) begin
      d.act = q.stg;
      // calibration only on a 0 to 1 change of the committed bit, so clearing rearms it
      d.ctrl.cal_start = q.stg.cal[CAL_BIT] && !q.act.cal[CAL_BIT];
    end

    // power-up reload from the stored image without host action
    if (q.boot) begin
      d.boot = 1'b0;
      if (NV_VALID) begin
        d.stg = q.nv;
        d.act = q.nv;
      end
    end

    d.ctrl     = ctrl_from(d.act, d.ctrl.cal_start);
    d.sdo_oe_n = ~((d.st == ST_DATA) && d.instr[15]);

    // reset defaults; the stored image survives reset
    if (RST) begin
      d          = '0;
      d.stg      = CFG_RESET;
      d.act      = CFG_RESET;
      d.nv       = q.nv;
      d.ctrl     = ctrl_from(CFG_RESET, 1'b0);
      d.st       = ST_IDLE;
      d.sdo_oe_n = 1'b1;
      d.sclk_q   = SCLK;
      d.boot     = 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    q <= d;
  end

  assign SDO      = q.sdo;
  assign SDO_OE_N = q.sdo_oe_n;
  assign CLK_CTRL = q.ctrl;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  sequence s_update;
    upd_wr && !q.boot;
  endsequence

  sequence s_stage;
    stage_wr && !upd_wr;
  endsequence

  a_pwr_follow: assert property (s_update |=>
    CLK_CTRL.pll_pwr_down == ($past(q.stg.pll[1:0]) == PWR_ASYNC_DOWN))
    else $error("PLL power-down does not follow committed field");

  a_src_follow: assert property (s_update |=>
    CLK_CTRL.src_vco == $past(q.stg.src[SRC_VCO_BIT]))
    else $error("Source select does not follow committed bit");

  a_bypass_follow: assert property (s_update |=>
    CLK_CTRL.div_bypass == $past(q.stg.src[DIV_BYP_BIT]))
    else $error("Divider bypass does not follow committed bit");

  a_div_range: assert property (
    CLK_CTRL.div_ratio >= 3'h1 && CLK_CTRL.div_ratio <= 3'h6)
    else $error("Divide ratio out of range");

  a_cal_start: assert property (s_update ##0 (q.stg.cal[CAL_BIT] && !q.act.cal[CAL_BIT])
    |=> CLK_CTRL.cal_start ##1 !CLK_CTRL.cal_start)
    else $error("Calibration start pulse missing");

  a_cal_rearm: assert property (s_update ##0 q.act.cal[CAL_BIT] |=> !CLK_CTRL.cal_start)
    else $error("Calibration restarted without clearing the bit");

  a_ref_follow: assert property (s_update |=> CLK_CTRL.ref_en == $past(q.stg.refen[2:0]))
    else $error("Reference enables do not follow committed field");

  a_pfd_follow: assert property (s_update |=>
    CLK_CTRL.pfd_negative == $past(q.stg.pll[PFD_POL_BIT]))
    else $error("PFD polarity does not follow committed bit");

  a_reset_dflt: assert property (@(posedge CLK) $past(RST) |->
    CLK_CTRL.pll_pwr_down && !CLK_CTRL.src_vco && !CLK_CTRL.div_bypass
    && CLK_CTRL.div_ratio == 3'h2)
    else $error("Reset defaults wrong");

  a_ext_osc: assert property (!CLK_CTRL.pll_pwr_down && !CLK_CTRL.src_vco
    && q.act.pll[1:0] == PWR_NORMAL |-> CLK_CTRL.prescaler_ext && !CLK_CTRL.vco_power_on)
    else $error("External oscillator path wrong");

  a_nv_save: assert property (nv_save_wr |=> q.nv == $past(q.act))
    else $error("Stored image does not match active settings");

  a_stage_hold: assert property (s_stage |=> CLK_CTRL == $past(CLK_CTRL))
    else $error("Staged write reached control outputs");

  sequence s_boot_load;
    q.boot && NV_VALID;
  endsequence

  sequence s_nv_load;
    wr_en && (wr_addr == ADDR_NV_CTRL) && wbyte[NV_LOAD_BIT] && !q.boot;
  endsequence

  a_div_follow: assert property (s_update |=>
    CLK_CTRL.div_ratio == (($past(q.stg.div[2:0]) <= 3'h4) ?
                           ($past(q.stg.div[2:0]) + 3'h2) : 3'h1))
    else $error("Divide ratio does not follow committed code");

  a_commit_all: assert property (s_update |=> q.act == $past(q.stg))
    else $error("Update did not commit all staged registers");

  a_boot_load: assert property (s_boot_load |=>
    q.act == $past(q.nv) && q.stg == $past(q.nv) && !CLK_CTRL.cal_start)
    else $error("Stored image not reloaded after reset");

  a_nv_load: assert property (s_nv_load |=>
    q.stg == $past(q.nv) && CLK_CTRL == $past(CLK_CTRL))
    else $error("Image load did not land in staging only");

  a_pwr_off_paths: assert property (CLK_CTRL.pll_pwr_down |->
    !CLK_CTRL.vco_power_on && !CLK_CTRL.prescaler_ext)
    else $error("Clock paths powered while PLL is down");

  a_vco_path: assert property (CLK_CTRL.src_vco && q.act.pll[1:0] == PWR_NORMAL |->
    CLK_CTRL.vco_power_on && !CLK_CTRL.prescaler_ext)
    else $error("VCO path not powered with VCO selected");

  a_cal_cause: assert property (CLK_CTRL.cal_start |->
    $past(upd_wr) && $past(q.stg.cal[CAL_BIT]))
    else $error("Calibration pulse without a committed set bit");

  a_cal_once: assert property (CLK_CTRL.cal_start |=> !CLK_CTRL.cal_start)
    else $error("Calibration pulse longer than one cycle");

  a_stage_no_cal: assert property (s_stage |=> !CLK_CTRL.cal_start)
    else $error("Staged write started a calibration");

  a_ctrl_cause: assert property (CLK_CTRL != $past(CLK_CTRL) && !$past(RST) |->
    $past(upd_wr) || $past(q.boot) || $past(CLK_CTRL.cal_start))
    else $error("Control outputs changed without an update");

endmodule // pcs_clock_source_config

// [dv/pcs_host_model.sv]
// Serial host model that frames reads and writes toward the configuration block
`timescale 1ns/100ps
module pcs_host_model (
  // Clock
  input  wire logic clk,
  // Serial port
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo,
  input  wire logic sdo_oe_n
);
  // Four cycles per serial phase, above the one-cycle minimum
  localparam int HALF = 4;

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end

  task automatic xfer(input logic rd, input logic [12:0] a, input logic [7:0] wd,
                      output logic [7:0] rdat, output logic oe_ok);
    logic [23:0] f;
    f = {rd, 2'b00, a, wd};
    oe_ok = 1'b1;
    @(negedge clk);
    cs_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdi  = f[i];
      sclk = 1'b0;
      repeat (HALF) @(negedge clk);
      // Read bits are taken just before the next rise
      if (i < 8) begin
        rdat[i] = sdo;
        oe_ok &= (sdo_oe_n === 1'b0);
      end
      sclk = 1'b1;
      repeat (HALF) @(negedge clk);
    end
    sclk = 1'b0;
    repeat (HALF) @(negedge clk);
    cs_n = 1'b1;
    // Idle data line flips so a stale level is never mistaken for data
    sdi = ~sdi;
    repeat (2) @(negedge clk);
  endtask
endmodule // pcs_host_model

// [dv/pcs_clock_source_config_tb.sv]
// Self-checking testbench for the clock source configuration block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module pcs_clock_source_config_tb import pcs_pkg::*;;
  logic      clk, rst, nv_valid, sclk, cs_n, sdi, sdo, sdo_oe_n;
  pcs_ctrl_t clk_ctrl;
  int        miscompares = 0;
  int        cmp_count   = 0;
  int        cal_n       = 0;
  logic [12:0] ra [5] = '{ADDR_PLL_CTRL, ADDR_VCO_CAL, ADDR_REF_EN, ADDR_VCO_DIV, ADDR_SRC_SEL};
  logic [7:0]  rv [5] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00};

  pcs_clock_source_config pcs_clock_source_config_inst (
    .CLK(clk), .RST(rst), .SCLK(sclk), .CS_N(cs_n), .SDI(sdi), .SDO(sdo),
    .SDO_OE_N(sdo_oe_n), .NV_VALID(nv_valid), .CLK_CTRL(clk_ctrl));
  pcs_host_model pcs_host_model_inst (
    .clk(clk), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Calibration pulses are counted mid-cycle, clear of the launching edge
  always @(negedge clk) begin
    if (clk_ctrl.cal_start === 1'b1) cal_n++;
  end

  // f packs power-down, VCO on, external prescaler, source, bypass
  function automatic pcs_ctrl_t mk(logic [4:0] f, logic [2:0] r, logic p, logic [2:0] e);
    return {f, r, p, e, 1'b0};
  endfunction

  task automatic tally_and_finish;
    if (miscompares == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic       ok;
    pcs_host_model_inst.xfer(1'b0, a, d, r, ok);
    `CHK("write_sdo", 8'h00, r)
  endtask

  task automatic rd(input logic [12:0] a, input logic [7:0] e);
    logic [7:0] r;
    logic       ok;
    pcs_host_model_inst.xfer(1'b1, a, 8'h5a, r, ok);
    `CHK("read_data", e, r)
    `CHK("read_oe", 1'b1, ok)
    `CHK("idle_oe", 1'b1, sdo_oe_n)
  endtask

  task automatic upd;
    wr(ADDR_UPDATE, 8'h01);
    repeat (2) @(negedge clk);
  endtask

  task automatic chk(input pcs_ctrl_t e);
    `CHK("clk_ctrl", e, clk_ctrl)
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    tally_and_finish();
  end

  initial begin
    rst = 1'b1;
    nv_valid = 1'b0;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    chk(mk(5'b10000, 3'd2, 1'b0, 3'd0));
    for (int i = 0; i < 5; i++) rd(ra[i], rv[i]);
    rd(13'h0123, 8'h00);
    rd(ADDR_UPDATE, 8'h00);
    wr(ADDR_SRC_SEL, 8'h02);
    chk(mk(5'b10000, 3'd2, 1'b0, 3'd0));
    rd(ADDR_SRC_SEL, 8'h02);
    // Power on with VCO source (host side)
    wr(ADDR_PLL_CTRL, 8'h80);
    wr(ADDR_REF_EN, 8'h05);
    wr(ADDR_VCO_DIV, 8'h03);
    // First calibration after power-up
    wr(ADDR_VCO_CAL, 8'h01);
    upd();
    `CHK("cal_pulses", 1, cal_n)
    chk(mk(5'b01010, 3'd5, 1'b1, 3'd5));
    upd();
    `CHK("cal_pulses", 1, cal_n)
    // Recalibration clears and commits first
    wr(ADDR_VCO_CAL, 8'h00);
    upd();
    wr(ADDR_VCO_CAL, 8'h01);
    upd();
    `CHK("cal_pulses", 2, cal_n)
    // Slow external source may skip the divider
    wr(ADDR_SRC_SEL, 8'h01);
    upd();
    chk(mk(5'b00101, 3'd5, 1'b1, 3'd5));
    wr(ADDR_NV_CTRL, 8'h01);
    wr(ADDR_PLL_CTRL, 8'h01);
    // Codes above 100b fall back to divide-by-1
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_VCO_DIV, 8'(c));
      upd();
      chk(mk(5'b10001, (c < 5) ? 3'(c + 2) : 3'd1, 1'b0, 3'd5));
    end
    // Stored image back into staging, live only after an update
    wr(ADDR_NV_CTRL, 8'h02);
    chk(mk(5'b10001, 3'd1, 1'b0, 3'd5));
    rd(ADDR_VCO_DIV, 8'h03);
    upd();
    chk(mk(5'b00101, 3'd5, 1'b1, 3'd5));
    `CHK("cal_pulses", 2, cal_n)
    rst = 1'b1;
    nv_valid = 1'b1;
    repeat (2) @(negedge clk);
    chk(mk(5'b10000, 3'd2, 1'b0, 3'd0));
    rst = 1'b0;
    repeat (4) @(negedge clk);
    chk(mk(5'b00101, 3'd5, 1'b1, 3'd5));
    rd(ADDR_SRC_SEL, 8'h01);
    tally_and_finish();
  end
endmodule // pcs_clock_source_config_tb
